//--- core/camm_params.svh
// register addresses, field positions and reset values of the counter array mode control
`ifndef CAMM_PARAMS_SVH
`define CAMM_PARAMS_SVH

`define CAMM_CYCLE_LEN_ADDR   8'hD9
`define CAMM_MODE0_ADDR       8'hDA
`define CAMM_MODE1_ADDR       8'hDB
`define CAMM_MODE2_ADDR       8'hDC
`define CAMM_MODE3_ADDR       8'hDD
`define CAMM_MODE4_ADDR       8'hDE
`define CAMM_MODE5_ADDR       8'hDF
`define CAMM_CNT_LO_ADDR      8'hF9
`define CAMM_CNT_HI_ADDR      8'hFA
`define CAMM_CC0_LO_ADDR      8'hFB
`define CAMM_CC1_LO_ADDR      8'hE9
`define CAMM_CC2_LO_ADDR      8'hEB
`define CAMM_CC3_LO_ADDR      8'hED
`define CAMM_CC4_LO_ADDR      8'hFD
`define CAMM_CC5_LO_ADDR      8'hCE
`define CAMM_CC0_HI_ADDR      8'hFC
`define CAMM_CC1_HI_ADDR      8'hEA
`define CAMM_CC2_HI_ADDR      8'hEC
`define CAMM_CC3_HI_ADDR      8'hEE
`define CAMM_CC4_HI_ADDR      8'hFE
`define CAMM_CC5_HI_ADDR      8'hCF

`define CAMM_BIT_WIDE_PWM     7
`define CAMM_BIT_CMP_EN       6
`define CAMM_BIT_CAP_RISE     5
`define CAMM_BIT_CAP_FALL     4
`define CAMM_BIT_MATCH        3
`define CAMM_BIT_TOGGLE       2
`define CAMM_BIT_PWM          1
`define CAMM_BIT_IRQ_EN       0

`define CAMM_BYTE_RESET       8'h00
`define CAMM_WORD_RESET       16'h0000
`define CAMM_CYCLE_LEN_RESET  2'h0
`define CAMM_UNMAPPED_READ    8'h00

`endif

//--- core/camm_pkg.sv
// types shared by the counter array mode control
package camm_pkg;
  typedef enum logic [2:0] {
    camm_mode_idle    = 3'b000,
    camm_mode_capture = 3'b001,
    camm_mode_timer   = 3'b010,
    camm_mode_toggle  = 3'b011,
    camm_mode_freq    = 3'b100,
    camm_mode_pwm_n   = 3'b101,
    camm_mode_pwm16   = 3'b110
  } camm_mode_t;
  typedef logic [7:0]  camm_byte_t;
  typedef logic [15:0] camm_word_t;
endpackage

//--- core/camm_chan.sv
// one capture/compare module: mode decode, edge capture, match and pin waveform
`timescale 1ns/1ps
`include "camm_params.svh"
module camm_chan (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_b,
  // configuration
  input  wire camm_pkg::camm_byte_t mode_bits,
  input  wire camm_pkg::camm_word_t cc_val,
  input  wire logic [1:0]         cycle_len,
  // shared counter
  input  wire camm_pkg::camm_word_t cnt,
  input  wire logic               cnt_moved,
  // pin
  input  wire logic               pin_in,
  output logic                    pin_out_q,
  output logic                    pin_oe_q,
  // events toward the register file
  output logic                    capture_hit,
  output logic                    match_hit,
  output logic                    freq_step
);

  function automatic camm_pkg::camm_mode_t decode_mode(input camm_pkg::camm_byte_t m);
    if (m[`CAMM_BIT_PWM] && m[`CAMM_BIT_TOGGLE]) begin
      decode_mode = camm_pkg::camm_mode_freq;
    end else if (m[`CAMM_BIT_PWM]) begin
      decode_mode = m[`CAMM_BIT_WIDE_PWM] ? camm_pkg::camm_mode_pwm16 : camm_pkg::camm_mode_pwm_n;
    end else if (m[`CAMM_BIT_TOGGLE]) begin
      decode_mode = camm_pkg::camm_mode_toggle;
    end else if (m[`CAMM_BIT_MATCH]) begin
      decode_mode = camm_pkg::camm_mode_timer;
    end else if (m[`CAMM_BIT_CAP_RISE] || m[`CAMM_BIT_CAP_FALL]) begin
      decode_mode = camm_pkg::camm_mode_capture;
    end else begin
      decode_mode = camm_pkg::camm_mode_idle;
    end
  endfunction

  function automatic camm_pkg::camm_word_t len_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    len_mask = 16'h00FF;
      2'h1:    len_mask = 16'h01FF;
      2'h2:    len_mask = 16'h03FF;
      default: len_mask = 16'h07FF;
    endcase
  endfunction

  camm_pkg::camm_mode_t mode;
  camm_pkg::camm_word_t mask;
  logic                 pin_prev_q;
  logic                 cmp_en;
  logic                 full_eq;
  logic                 low_eq;
  logic                 rise;
  logic                 fall;
  logic                 pwm_level;

  assign mode      = decode_mode(mode_bits);
  assign mask      = len_mask(cycle_len);
  assign cmp_en    = mode_bits[`CAMM_BIT_CMP_EN];
  assign full_eq   = (cnt == cc_val);
  assign low_eq    = (cnt[7:0] == cc_val[7:0]);
  assign rise      = pin_in & ~pin_prev_q;
  assign fall      = ~pin_in & pin_prev_q;
  assign pwm_level = ((cnt & mask) >= (cc_val & mask));

  // either or both edge bits may qualify an edge
  assign capture_hit = (rise & mode_bits[`CAMM_BIT_CAP_RISE]) | (fall & mode_bits[`CAMM_BIT_CAP_FALL]);
  // only a fresh counter value counts, so a stopped counter does not flood the flag
  assign match_hit   = cmp_en & mode_bits[`CAMM_BIT_MATCH] & cnt_moved & full_eq;
  assign freq_step   = cmp_en & cnt_moved & low_eq & (mode == camm_pkg::camm_mode_freq);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_q <= 1'b0;
    end else begin
      case (mode)
        camm_pkg::camm_mode_toggle: begin
          if (cmp_en && cnt_moved && full_eq) begin
            pin_out_q <= ~pin_out_q;
          end
        end
        camm_pkg::camm_mode_freq: begin
          if (freq_step) begin
            pin_out_q <= ~pin_out_q;
          end
        end
        camm_pkg::camm_mode_pwm_n: begin
          pin_out_q <= cmp_en & pwm_level;
        end
        camm_pkg::camm_mode_pwm16: begin
          pin_out_q <= cmp_en & full_eq | cmp_en & (cnt > cc_val);
        end
        default: begin
          pin_out_q <= pin_out_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= (mode == camm_pkg::camm_mode_toggle) || (mode == camm_pkg::camm_mode_freq) ||
                  (mode == camm_pkg::camm_mode_pwm_n) || (mode == camm_pkg::camm_mode_pwm16);
    end
  end

endmodule

//--- core/camm_top.sv
// counter array: shared counter, module mode and capture/compare registers, register port
`timescale 1ns/1ps
`include "camm_params.svh"
// Function
// - wide-PWM bit 7 picks 16-bit PWM, else shared 8-11 bit cycle.
// - bit 6 enables the comparator that compare modes need.
// - bit 5 captures on a rising pin edge.
// - bit 4 captures on a falling pin edge; both bits capture either edge.
// - match bit 3 sets the module flag when the counter moves onto the compare value, with bit 6 set.
// - toggle bit 2 inverts the module pin on each counter match.
// - toggle plus PWM together select frequency output mode.
// - bit 1 enables PWM and drives a PWM waveform on the pin.
// - bit 0 gates the module flag onto its interrupt request.
// - watchdog enabled blocks writes to module 5 mode register.
// - watchdog enabled blocks software writes to the counter low byte.
// - high byte reads a snapshot loaded only by low byte reads.
// - watchdog enabled blocks software writes to the counter high byte.
// - sixteen-bit counter with readable writable bytes, both reset to zero.
// - shared two-bit field picks 8, 9, 10 or 11 bit cycle.
// - writing compare low byte clears the comparator-enable bit.
// - writing compare high byte sets the comparator-enable bit.
module camm_top #(
  parameter int NUM_MODULES = 6,
  parameter int WDOG_MODULE = 5,
  parameter int CNT_W       = 16
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  // register port
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr_en,
  input  wire logic                   sfr_rd_en,
  input  wire logic [7:0]             sfr_wdata,
  output logic [7:0]                  sfr_rdata_q,
  // loose control
  input  wire logic                   watchdog_enable,
  input  wire logic                   count_tick,
  input  wire logic [NUM_MODULES-1:0] event_flag_clear,
  // module pins
  input  wire logic [NUM_MODULES-1:0] module_io_pin_in,
  output logic [NUM_MODULES-1:0]      module_io_pin_out,
  output logic [NUM_MODULES-1:0]      module_io_pin_oe,
  // status
  output logic [NUM_MODULES-1:0]      module_event_flag,
  output logic [NUM_MODULES-1:0]      module_irq_req
);

  // register addresses are fixed per module, so the module count cannot change
  if (NUM_MODULES != 6) begin : g_bad_count
    $error("camm_top: NUM_MODULES must be 6");
  end
  if (WDOG_MODULE < 0 || WDOG_MODULE >= NUM_MODULES) begin : g_bad_wdog
    $error("camm_top: WDOG_MODULE out of range");
  end
  if (CNT_W != 16) begin : g_bad_width
    $error("camm_top: CNT_W must be 16");
  end

  function automatic logic [7:0] mode_addr(input int idx);
    case (idx)
      0:       mode_addr = `CAMM_MODE0_ADDR;
      1:       mode_addr = `CAMM_MODE1_ADDR;
      2:       mode_addr = `CAMM_MODE2_ADDR;
      3:       mode_addr = `CAMM_MODE3_ADDR;
      4:       mode_addr = `CAMM_MODE4_ADDR;
      default: mode_addr = `CAMM_MODE5_ADDR;
    endcase
  endfunction

  function automatic logic [7:0] cc_lo_addr(input int idx);
    case (idx)
      0:       cc_lo_addr = `CAMM_CC0_LO_ADDR;
      1:       cc_lo_addr = `CAMM_CC1_LO_ADDR;
      2:       cc_lo_addr = `CAMM_CC2_LO_ADDR;
      3:       cc_lo_addr = `CAMM_CC3_LO_ADDR;
      4:       cc_lo_addr = `CAMM_CC4_LO_ADDR;
      default: cc_lo_addr = `CAMM_CC5_LO_ADDR;
    endcase
  endfunction

  function automatic logic [7:0] cc_hi_addr(input int idx);
    case (idx)
      0:       cc_hi_addr = `CAMM_CC0_HI_ADDR;
      1:       cc_hi_addr = `CAMM_CC1_HI_ADDR;
      2:       cc_hi_addr = `CAMM_CC2_HI_ADDR;
      3:       cc_hi_addr = `CAMM_CC3_HI_ADDR;
      4:       cc_hi_addr = `CAMM_CC4_HI_ADDR;
      default: cc_hi_addr = `CAMM_CC5_HI_ADDR;
    endcase
  endfunction

  logic [CNT_W-1:0]         cnt_q;
  logic [CNT_W-1:0]         cnt_d;
  logic                     cnt_moved_q;
  logic [7:0]               snap_q;
  logic [1:0]               cycle_len_q;
  logic [7:0]               rdata_d;
  logic                     wr_cnt_lo;
  logic                     wr_cnt_hi;
  logic                     rd_cnt_lo;
  logic [8*NUM_MODULES-1:0] mode_flat;
  logic [16*NUM_MODULES-1:0] cc_flat;

  assign wr_cnt_lo = sfr_wr_en && (sfr_addr == `CAMM_CNT_LO_ADDR) && !watchdog_enable;
  assign wr_cnt_hi = sfr_wr_en && (sfr_addr == `CAMM_CNT_HI_ADDR) && !watchdog_enable;
  assign rd_cnt_lo = sfr_rd_en && (sfr_addr == `CAMM_CNT_LO_ADDR);

  // a software byte write wins over a tick in the same cycle
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt_lo) begin
      cnt_d = {cnt_q[15:8], sfr_wdata};
    end else if (wr_cnt_hi) begin
      cnt_d = {sfr_wdata, cnt_q[7:0]};
    end else if (count_tick) begin
      cnt_d = 16'(cnt_q + 16'h0001);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= `CAMM_WORD_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // marks a fresh counter value so that a match fires once per value
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_moved_q <= 1'b0;
    end else begin
      cnt_moved_q <= wr_cnt_lo | wr_cnt_hi | count_tick;
    end
  end

  // reading the low byte freezes the high byte for a torn-free 16-bit read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      snap_q <= `CAMM_BYTE_RESET;
    end else if (rd_cnt_lo) begin
      snap_q <= cnt_q[15:8];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cycle_len_q <= `CAMM_CYCLE_LEN_RESET;
    end else if (sfr_wr_en && (sfr_addr == `CAMM_CYCLE_LEN_ADDR)) begin
      cycle_len_q <= sfr_wdata[1:0];
    end
  end

  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
    logic [7:0]  mode_q;
    logic [15:0] cc_q;
    logic        flag_q;
    logic        irq_q;
    logic        lock;
    logic        wr_mode;
    logic        wr_lo;
    logic        wr_hi;
    logic        capture_hit;
    logic        match_hit;
    logic        freq_step;
    logic        pin_out_q;
    logic        pin_oe_q;

    // the watchdog owns its module's mode register while enabled, including the compare-enable side effects
    assign lock    = watchdog_enable && (i == WDOG_MODULE);
    assign wr_mode = sfr_wr_en && (sfr_addr == mode_addr(i)) && !lock;
    assign wr_lo   = sfr_wr_en && (sfr_addr == cc_lo_addr(i));
    assign wr_hi   = sfr_wr_en && (sfr_addr == cc_hi_addr(i));

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        mode_q <= `CAMM_BYTE_RESET;
      end else if (wr_mode) begin
        mode_q <= sfr_wdata;
      end else if (wr_lo && !lock) begin
        mode_q[`CAMM_BIT_CMP_EN] <= 1'b0;
      end else if (wr_hi && !lock) begin
        mode_q[`CAMM_BIT_CMP_EN] <= 1'b1;
      end
    end

    // software writes win over capture; capture wins over the frequency step
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        cc_q <= `CAMM_WORD_RESET;
      end else if (wr_lo) begin
        cc_q[7:0] <= sfr_wdata;
      end else if (wr_hi) begin
        cc_q[15:8] <= sfr_wdata;
      end else if (capture_hit) begin
        cc_q <= cnt_q;
      end else if (freq_step) begin
        cc_q[7:0] <= 8'(cc_q[7:0] + cc_q[15:8]);
      end
    end

    // a set in the same cycle as a clear wins
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        flag_q <= 1'b0;
      end else if (capture_hit || match_hit) begin
        flag_q <= 1'b1;
      end else if (event_flag_clear[i]) begin
        flag_q <= 1'b0;
      end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        irq_q <= 1'b0;
      end else begin
        irq_q <= flag_q & mode_q[`CAMM_BIT_IRQ_EN];
      end
    end

    camm_chan u_chan (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .mode_bits   (mode_q),
      .cc_val      (cc_q),
      .cycle_len   (cycle_len_q),
      .cnt         (cnt_q),
      .cnt_moved   (cnt_moved_q),
      .pin_in      (module_io_pin_in[i]),
      .pin_out_q   (pin_out_q),
      .pin_oe_q    (pin_oe_q),
      .capture_hit (capture_hit),
      .match_hit   (match_hit),
      .freq_step   (freq_step)
    );

    assign mode_flat[8*i +: 8]   = mode_q;
    assign cc_flat[16*i +: 16]   = cc_q;
    assign module_event_flag[i]  = flag_q;
    assign module_irq_req[i]     = irq_q;
    assign module_io_pin_out[i]  = pin_out_q;
    assign module_io_pin_oe[i]   = pin_oe_q;
  end

  // unmapped addresses read as zero; the cycle-length register reads zero above bit 1
  always_comb begin
    rdata_d = `CAMM_UNMAPPED_READ;
    if (sfr_addr == `CAMM_CNT_LO_ADDR) begin
      rdata_d = cnt_q[7:0];
    end else if (sfr_addr == `CAMM_CNT_HI_ADDR) begin
      rdata_d = snap_q;
    end else if (sfr_addr == `CAMM_CYCLE_LEN_ADDR) begin
      rdata_d = {6'h00, cycle_len_q};
    end
    for (int k = 0; k < NUM_MODULES; k++) begin
      if (sfr_addr == mode_addr(k)) begin
        rdata_d = mode_flat[8*k +: 8];
      end
      if (sfr_addr == cc_lo_addr(k)) begin
        rdata_d = cc_flat[16*k +: 8];
      end
      if (sfr_addr == cc_hi_addr(k)) begin
        rdata_d = cc_flat[16*k+8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q <= `CAMM_BYTE_RESET;
    end else if (sfr_rd_en) begin
      sfr_rdata_q <= rdata_d;
    end
  end

endmodule

//--- tb/camm_top_sva.sv
// port-level checker of the counter array mode control
`timescale 1ns/1ps
module camm_top_chk #(
  parameter int NUM_MODULES = 6
) (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_b,
  // register port
  input wire logic [7:0]             sfr_addr,
  input wire logic                   sfr_wr_en,
  input wire logic                   sfr_rd_en,
  input wire logic [7:0]             sfr_wdata,
  input wire logic [7:0]             sfr_rdata_q,
  // loose control
  input wire logic                   watchdog_enable,
  input wire logic                   count_tick,
  input wire logic [NUM_MODULES-1:0] event_flag_clear,
  // pins and status
  input wire logic [NUM_MODULES-1:0] module_io_pin_in,
  input wire logic [NUM_MODULES-1:0] module_io_pin_out,
  input wire logic [NUM_MODULES-1:0] module_io_pin_oe,
  input wire logic [NUM_MODULES-1:0] module_event_flag,
  input wire logic [NUM_MODULES-1:0] module_irq_req
);
  logic [7:0] m0_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // shadow of module 0 mode; compare-byte writes move its comparator bit too
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      m0_q <= 8'h00;
    end else if (sfr_wr_en && sfr_addr == 8'hDA) begin
      m0_q <= sfr_wdata;
    end else if (sfr_wr_en && sfr_addr == 8'hFB) begin
      m0_q[6] <= 1'b0;
    end else if (sfr_wr_en && sfr_addr == 8'hFC) begin
      m0_q[6] <= 1'b1;
    end
  end
  a_irq_gated: assert property (module_irq_req[0] == $past(module_event_flag[0] & m0_q[0]))
    else $error("irq of module 0 not flag and enable");
  a_irq_needs_flag: assert property ((module_irq_req & ~$past(module_event_flag)) == '0)
    else $error("irq without flag");
  a_flag_sticky: assert property ((~module_event_flag & $past(module_event_flag & ~event_flag_clear)) == '0)
    else $error("flag dropped without clear");
  a_flag_cause: assert property ($rose(module_event_flag[0]) |-> $past(m0_q[5:3]) != 3'b000)
    else $error("flag set without match or capture mode");
  a_oe_mode: assert property (module_io_pin_oe[0] == $past(m0_q[2] | m0_q[1]))
    else $error("pin enable does not follow mode");
  a_pwm_off_low: assert property ($past(m0_q[2:1] == 2'b01 && !m0_q[6]) |-> !module_io_pin_out[0])
    else $error("pwm pin high with comparator off");
  a_rdata_holds: assert property (!$past(sfr_rd_en) |-> $stable(sfr_rdata_q))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (sfr_rd_en && sfr_addr == 8'h00 |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (sfr_rd_en && sfr_addr == 8'hDA |=> sfr_rdata_q == $past(m0_q))
    else $error("mode 0 readback wrong");
  c_flag_set: cover property ($rose(module_event_flag[0]));
  c_irq_set: cover property ($rose(module_irq_req[0]));
  c_pin_toggle: cover property ($changed(module_io_pin_out[0]));
endmodule
bind camm_top camm_top_chk #(.NUM_MODULES(NUM_MODULES)) camm_top_chk_i (
  .mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
  .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .watchdog_enable(watchdog_enable),
  .count_tick(count_tick), .event_flag_clear(event_flag_clear), .module_io_pin_in(module_io_pin_in),
  .module_io_pin_out(module_io_pin_out), .module_io_pin_oe(module_io_pin_oe),
  .module_event_flag(module_event_flag), .module_irq_req(module_irq_req)
);

//--- tb/camm_pin_model.sv
// far side of the module pins
`timescale 1ns/1ps
module camm_pin_model (
  // design side
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  // level the outside world puts on undriven pins
  input wire logic [5:0] ext_lvl,
  output logic [5:0]     pin_in
);
  // a driven pin reads back its own level, so the outside level is ignored there
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

//--- tb/testbench.sv
// self-checking bench of the counter array mode control
`timescale 1ns/1ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); \
  end \
end
module testbench;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr_en = 1'b0;
  logic        sfr_rd_en = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata_q;
  logic        watchdog_enable = 1'b0;
  logic        count_tick = 1'b0;
  logic [5:0]  event_flag_clear = 6'h00;
  logic [5:0]  ext_lvl = 6'h00;
  logic [5:0]  pin_in, pin_out, pin_oe, flag, irq;
  logic [7:0]  r;
  logic        p;
  int          failures = 0;
  int          total_checks = 0;
  // address, written value, value read back
  logic [23:0] rows [9] = '{24'hDAA5A5, 24'hDB5A5A, 24'hDC3C3C, 24'hDDC3C3, 24'hDE0F0F, 24'hDF8181,
                            24'hD9FF03, 24'h005500, 24'hFB1212};
  // cycle code, mode, pin level with compare 0x0180 and counter 0x0290
  logic [15:0] pw [6] = '{16'h1420, 16'h1C21, 16'h0421, 16'h2421, 16'h3421, 16'h0020};
  camm_top camm_top_i (
    .mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .watchdog_enable(watchdog_enable),
    .count_tick(count_tick), .event_flag_clear(event_flag_clear), .module_io_pin_in(pin_in),
    .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .module_event_flag(flag), .module_irq_req(irq)
  );
  camm_pin_model camm_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  always #25 mclk = ~mclk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge mclk);
    sfr_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd_en <= 1'b1;
    @(posedge mclk);
    sfr_rd_en <= 1'b0;
    @(negedge mclk);
    r = sfr_rdata_q;
  endtask
  task automatic cnt(input logic [15:0] v);
    wr(8'hF9, v[7:0]);
    wr(8'hFA, v[15:8]);
  endtask
  task automatic clr();
    @(posedge mclk);
    event_flag_clear <= 6'h3F;
    @(posedge mclk);
    event_flag_clear <= 6'h00;
  endtask
  // one tick from 4 onto the compare value 5; flag lands two edges later, irq one more
  task automatic hit();
    cnt(16'h0004);
    clr();
    @(negedge mclk);
    p = pin_out[0];
    @(posedge mclk);
    count_tick <= 1'b1;
    @(posedge mclk);
    count_tick <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic pin(input logic l);
    @(posedge mclk);
    ext_lvl <= {4'h0, l, 1'b0};
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i][23:16]);
      `CHK(r, 8'h00)
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      `CHK(r, rows[i][7:0])
    end
    $display("register table test done");
    rd(8'hF9);
    `CHK(r, 8'h00)
    rd(8'hFA);
    `CHK(r, 8'h00)
    cnt(16'h12FF);
    @(posedge mclk);
    count_tick <= 1'b1;
    @(posedge mclk);
    count_tick <= 1'b0;
    rd(8'hF9);
    `CHK(r, 8'h00)
    wr(8'hFA, 8'h77);
    rd(8'hFA);
    `CHK(r, 8'h13)
    rd(8'hF9);
    rd(8'hFA);
    `CHK(r, 8'h77)
    $display("counter snapshot test done");
    @(posedge mclk);
    watchdog_enable <= 1'b1;
    wr(8'hF9, 8'hAA);
    wr(8'hFA, 8'hBB);
    wr(8'hDF, 8'h01);
    rd(8'hF9);
    `CHK(r, 8'h00)
    rd(8'hFA);
    `CHK(r, 8'h77)
    rd(8'hDF);
    `CHK(r, 8'h81)
    @(posedge mclk);
    watchdog_enable <= 1'b0;
    wr(8'hDF, 8'h01);
    rd(8'hDF);
    `CHK(r, 8'h01)
    $display("watchdog lock test done");
    wr(8'hDA, 8'h49);
    wr(8'hFB, 8'h05);
    rd(8'hDA);
    `CHK(r, 8'h09)
    wr(8'hFC, 8'h00);
    rd(8'hDA);
    `CHK(r, 8'h49)
    hit();
    `CHK({flag[0], irq[0]}, 2'b11)
    wr(8'hDA, 8'h08);
    hit();
    `CHK(flag[0], 1'b0)
    wr(8'hDA, 8'h48);
    hit();
    `CHK({flag[0], irq[0]}, 2'b10)
    wr(8'hDA, 8'h44);
    hit();
    `CHK({pin_oe[0], pin_out[0], flag[0]}, {1'b1, ~p, 1'b0})
    wr(8'hFC, 8'h03);
    wr(8'hDA, 8'h46);
    hit();
    rd(8'hFB);
    `CHK({pin_out[0], r}, {~p, 8'h08})
    $display("match toggle frequency test done");
    wr(8'hFB, 8'h80);
    wr(8'hFC, 8'h01);
    cnt(16'h0290);
    foreach (pw[i]) begin
      wr(8'hD9, {4'h0, pw[i][15:12]});
      wr(8'hDA, pw[i][11:4]);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK({pin_oe[0], pin_out[0]}, {1'b1, pw[i][0]})
    end
    $display("pwm test done");
    wr(8'hDB, 8'h10);
    cnt(16'h1234);
    clr();
    pin(1'b1);
    `CHK(flag[1], 1'b0)
    wr(8'hDB, 8'h20);
    clr();
    pin(1'b0);
    `CHK(flag[1], 1'b0)
    pin(1'b1);
    rd(8'hE9);
    `CHK({flag[1], r}, {1'b1, 8'h34})
    rd(8'hEA);
    `CHK(r, 8'h12)
    wr(8'hDB, 8'h30);
    cnt(16'h2345);
    clr();
    pin(1'b0);
    rd(8'hE9);
    `CHK({flag[1], r}, {1'b1, 8'h45})
    $display("capture test done");
    // mid-run reset: every output drops at once, counter and snapshot come back as zero
    @(posedge mclk);
    rst_b <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    `CHK({flag, irq, pin_oe, pin_out, sfr_rdata_q}, 32'h0000_0000)
    @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'hF9);
    `CHK(r, 8'h00)
    rd(8'hFA);
    `CHK(r, 8'h00)
    $display("reset test done");
    results();
  end
endmodule
